/* File: rxp_pkg.sv */
// Shared constants and types of the E3 receive payload output port
package rxp_pkg;

   // ----------------------------------------------------------------
   // Sizes and counts
   // ----------------------------------------------------------------
   localparam int unsigned NIB_W       = 4;     // Nibble payload width
   localparam int unsigned NIB_PER_FRM = 1060;  // Nibble clock pulses per frame
   localparam int unsigned PULSE_CNT_W = 11;    // Holds NIB_PER_FRM
   localparam int unsigned FIFO_DEPTH  = 16;    // Default buffer depth
   localparam int unsigned MIN_DEPTH   = 4;     // Smallest buffer served
   localparam int unsigned BIT_CNT_W   = 2;     // Width of the bit counter within a nibble
   localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 2'h3;
   localparam logic [BIT_CNT_W-1:0] FIRST_BIT_IDX = 2'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // One received line bit with its qualifiers
   typedef struct packed {
      logic sof;   // First bit of a frame
      logic oh;    // Overhead bit, not payload
      logic data;  // Line bit value
   } rxp_item_s;

   localparam int unsigned ITEM_W = $bits(rxp_item_s);

   // Output format picked by the strap input
   typedef enum logic {
      RXP_MODE_SERIAL,
      RXP_MODE_NIBBLE
   } rxp_mode_e;

   // Drain side: wait for a fill mark, then stream
   typedef enum logic {
      RXP_FILL,
      RXP_RUN
   } rxp_drain_e;

endpackage : rxp_pkg

/* File: rxp_payload_port.sv */
// E3 receive payload output port with its clock-crossing buffer
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Dual-clock buffer with gray-coded pointers
// ----------------------------------------------------------------
module rxp_async_fifo
   import rxp_pkg::*;
#(
   parameter int unsigned W     = 3,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic                        wr_clk,
   input  wire logic                        wr_rstn,
   input  wire logic                        wr_valid,
   output logic                             wr_ready,
   input  wire logic [W-1:0]                wr_data,
   input  wire logic                        rd_clk,
   input  wire logic                        rd_rstn,
   output logic                             rd_valid,
   input  wire logic                        rd_ready,
   output logic [W-1:0]                     rd_data,
   output logic [$clog2(DEPTH):0]           rd_level
);
   localparam int unsigned AW = $clog2(DEPTH);

   // Refuse sizes the pointer logic cannot serve
   if (DEPTH < MIN_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("rxp_async_fifo: DEPTH must be a power of two of at least 4");
   end

   // Binary to gray
   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : bin2gray

   // Gray to binary
   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b = '0;
      for (int i = AW; i >= 0; i--) begin
         b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
      end
      return b;
   endfunction : gray2bin

   typedef struct packed {
      logic [AW:0] bin;   // Own pointer, binary
      logic [AW:0] gray;  // Own pointer, gray
      logic [AW:0] s1;    // Far pointer, first stage
      logic [AW:0] s2;    // Far pointer, second stage
   } rxp_ptr_s;

   logic [W-1:0] mem [DEPTH];
   rxp_ptr_s     w_q, w_d, r_q, r_d;
   logic         push;
   logic         pull;

   // Full when the synchronised far pointer trails by one lap
   // Only the second stage is read here, never the read clock's own flops
   assign wr_ready = (w_q.gray != {~w_q.s2[AW:AW-1], w_q.s2[AW-2:0]});
   assign push     = wr_valid && wr_ready;
   assign rd_valid = (r_q.gray != r_q.s2);
   assign pull     = rd_valid && rd_ready;
   assign rd_data  = mem[r_q.bin[AW-1:0]];
   assign rd_level = gray2bin(r_q.s2) - r_q.bin;

   // Write side next state
   always_comb begin
      w_d      = w_q;
      w_d.s1   = r_q.gray;
      w_d.s2   = w_q.s1;
      if (push) begin
         w_d.bin  = w_q.bin + 1'b1;
         w_d.gray = bin2gray(w_d.bin);
      end
   end

   // Read side next state
   always_comb begin
      r_d      = r_q;
      r_d.s1   = w_q.gray;
      r_d.s2   = r_q.s1;
      if (pull) begin
         r_d.bin  = r_q.bin + 1'b1;
         r_d.gray = bin2gray(r_d.bin);
      end
   end

   // Write side registers and storage
   always_ff @(posedge wr_clk or negedge wr_rstn) begin
      if (!wr_rstn) begin
         w_q <= '0;
      end else begin
         w_q <= w_d;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[w_q.bin[AW-1:0]] <= wr_data;
      end
   end

   // Read side registers
   always_ff @(posedge rd_clk or negedge rd_rstn) begin
      if (!rd_rstn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

endmodule : rxp_async_fifo

// ----------------------------------------------------------------
// Payload output port
// ----------------------------------------------------------------
// Summary of operation
// - Serial bits change on output clock rise
// - Serial output only active in serial mode
// - Nibble output changes on output clock fall
// - Nibble output only active in nibble mode
// - Serial mode clock runs continuously at line rate
// - Nibble mode gives 1060 clock pulses per frame
// - Overhead flag marks overhead serial bits
// - Overhead flag held low in nibble mode
// - Frame flag one bit on first serial bit
// - Frame flag one nibble on first nibble
// - Nibble clock high one line clock in four
module rxp_payload_port
   import rxp_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire rxp_item_s         in_item,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic              rx_recovered_line_clock,
   input  wire logic              nibble_mode_select,
   output logic                   rx_serial_payload_out,
   output logic [NIB_W-1:0]       rx_nibble_payload_out,
   output logic                   rx_payload_clock_out,
   output logic                   rx_overhead_bit_flag,
   output logic                   rx_frame_start_flag
);
   localparam int unsigned LW = $clog2(DEPTH) + 1;
   localparam logic [LW-1:0] FILL_MARK = LW'(DEPTH / 2);

   if (DEPTH < MIN_DEPTH) begin : g_chk
      $error("rxp_payload_port: DEPTH below 4");
   end

   // Whole line-side state
   typedef struct packed {
      logic                   mode_m;   // Strap, first stage
      rxp_mode_e              mode;     // Strap, settled
      rxp_drain_e             drain;
      logic                   ser;
      logic                   oh;
      logic                   fr;
      logic [NIB_W-1:0]       nib;
      logic [NIB_W-1:0]       hold;     // Assembled nibble awaiting fall
      logic                   hold_fr;
      logic                   clk;      // Nibble clock level
      logic [NIB_W-2:0]       shift;    // Payload bits so far
      logic [BIT_CNT_W-1:0]   cnt;
      logic                   pend;     // Frame start not yet attached
   } rxp_link_s;

   rxp_link_s      l_q, l_d;
   logic [1:0]     lrst_q;
   logic           lrst_n;
   logic           f_valid;
   logic           f_ready;
   logic           pop;
   rxp_item_s      f_item;
   logic [LW-1:0]  f_level;

   // ----------------------------------------------------------------
   // Crossing buffer between framer and line side
   // ----------------------------------------------------------------
   rxp_async_fifo #(
      .W     (ITEM_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .wr_clk   (sys_clk),
      .wr_rstn  (rstn),
      .wr_valid (in_valid),
      .wr_ready (in_ready),
      .wr_data  (in_item),
      .rd_clk   (rx_recovered_line_clock),
      .rd_rstn  (lrst_n),
      .rd_valid (f_valid),
      .rd_ready (f_ready),
      .rd_data  (f_item),
      .rd_level (f_level)
   );

   // Line-side reset: asserted at once, released on the line clock
   always_ff @(posedge rx_recovered_line_clock or negedge rstn) begin
      if (!rstn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign lrst_n = lrst_q[1];

   // Drain only while running; a stall lets the buffer fill
   assign f_ready = (l_q.drain == RXP_RUN);
   assign pop     = f_ready && f_valid;

   // ----------------------------------------------------------------
   // Line-side next state
   // ----------------------------------------------------------------
   always_comb begin
      l_d        = l_q;
      l_d.mode_m = nibble_mode_select;
      l_d.mode   = l_q.mode_m ? RXP_MODE_NIBBLE : RXP_MODE_SERIAL;
      unique case (l_q.drain)
         RXP_FILL: begin
            if (f_level >= FILL_MARK) begin
               l_d.drain = RXP_RUN;
            end
         end
         RXP_RUN: begin
            if (!f_valid) begin
               l_d.drain = RXP_FILL;
            end
         end
      endcase
      unique case (l_q.mode)
         RXP_MODE_SERIAL: begin
            // One line bit per rising edge, flags beside it
            l_d.nib  = '0;
            l_d.clk  = 1'b0;
            l_d.cnt  = FIRST_BIT_IDX;
            l_d.pend = 1'b0;
            if (pop) begin
               l_d.ser = f_item.data;
               l_d.oh  = f_item.oh;
               l_d.fr  = f_item.sof;
            end else begin
               l_d.ser = 1'b0;
               l_d.oh  = 1'b1;                        // Gap bit, to discard
               l_d.fr  = 1'b0;
            end
         end
         RXP_MODE_NIBBLE: begin
            l_d.ser = 1'b0;
            l_d.oh  = 1'b0;
            l_d.clk = 1'b0;
            // Nibble and its flag move on the clock fall
            if (l_q.clk) begin
               l_d.nib = l_q.hold;
               l_d.fr  = l_q.hold_fr;
            end
            // Gather payload bits, skip overhead
            if (pop) begin
               l_d.pend = l_q.pend | f_item.sof;
               if (!f_item.oh) begin
                  if (l_q.cnt == LAST_BIT_IDX) begin
                     l_d.hold    = {l_q.shift, f_item.data};
                     l_d.hold_fr = l_d.pend;
                     l_d.pend    = 1'b0;
                     l_d.clk     = 1'b1;
                     l_d.cnt     = FIRST_BIT_IDX;
                  end else begin
                     l_d.shift = {l_q.shift[NIB_W-3:0], f_item.data};
                     l_d.cnt   = l_q.cnt + 1'b1;
                  end
               end
            end
         end
      endcase
   end

   // Line-side registers
   always_ff @(posedge rx_recovered_line_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign rx_serial_payload_out = l_q.ser;
   assign rx_nibble_payload_out = l_q.nib;
   assign rx_overhead_bit_flag  = l_q.oh;
   assign rx_frame_start_flag   = l_q.fr;
   // Serial: line clock itself; nibble: derived pulse
   assign rx_payload_clock_out  = (l_q.mode == RXP_MODE_NIBBLE) ?
                                  l_q.clk : rx_recovered_line_clock;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [PULSE_CNT_W-1:0] pc_q;
   logic                   seen_q;

   // Nibble clock pulses since the last framed pulse
   always_ff @(posedge rx_recovered_line_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         pc_q   <= '0;
         seen_q <= 1'b0;
      end else if (l_q.mode != RXP_MODE_NIBBLE) begin
         pc_q   <= '0;
         seen_q <= 1'b0;
      end else if (l_q.clk) begin
         pc_q   <= l_q.hold_fr ? PULSE_CNT_W'(1) : pc_q + 1'b1;
         seen_q <= seen_q | l_q.hold_fr;
      end
   end

   default clocking cb @(posedge rx_recovered_line_clock); endclocking
   default disable iff (!lrst_n);

   property p_ser_follow;
      (pop && l_q.mode == RXP_MODE_SERIAL) |=>
         {l_q.fr, l_q.oh, l_q.ser} == $past(f_item);
   endproperty
   a_ser_follow: assert property (p_ser_follow)
      else $error("serial bit or flags do not follow the popped item");

   property p_ser_gap;
      (!pop && l_q.mode == RXP_MODE_SERIAL) |=> (l_q.oh && !l_q.fr);
   endproperty
   a_ser_gap: assert property (p_ser_gap)
      else $error("gap bit not flagged as overhead");

   property p_nib_quiet;
      (l_q.mode == RXP_MODE_NIBBLE) |=> (!l_q.ser && !l_q.oh);
   endproperty
   a_nib_quiet: assert property (p_nib_quiet)
      else $error("serial pin or overhead flag active in nibble mode");

   property p_ser_quiet;
      (l_q.mode == RXP_MODE_SERIAL) |=> (l_q.nib == '0 && !l_q.clk);
   endproperty
   a_ser_quiet: assert property (p_ser_quiet)
      else $error("nibble pins active in serial mode");

   property p_clk_duty;
      l_q.clk |=> !l_q.clk [*3];
   endproperty
   a_clk_duty: assert property (p_clk_duty)
      else $error("nibble clock high longer than one line clock");

   property p_nib_fall;
      (l_q.clk && l_q.mode == RXP_MODE_NIBBLE) |=>
         (l_q.nib == $past(l_q.hold) && l_q.fr == $past(l_q.hold_fr));
   endproperty
   a_nib_fall: assert property (p_nib_fall)
      else $error("nibble or frame flag not loaded on clock fall");

   property p_nib_hold;
      (l_q.mode == RXP_MODE_NIBBLE && !l_q.clk) |=> $stable(l_q.nib);
   endproperty
   a_nib_hold: assert property (p_nib_hold)
      else $error("nibble changed away from clock fall");

   property p_pulse_cnt;
      (l_q.clk && l_q.hold_fr && seen_q && l_q.mode == RXP_MODE_NIBBLE) |->
         pc_q == PULSE_CNT_W'(NIB_PER_FRM);
   endproperty
   a_pulse_cnt: assert property (p_pulse_cnt)
      else $error("nibble clock pulse count per frame is wrong");

   c_ser_frame:  cover property (pop && f_item.sof && l_q.mode == RXP_MODE_SERIAL);
   c_nib_frame:  cover property (l_q.clk && l_q.hold_fr);
   c_underrun:   cover property (l_q.drain == RXP_RUN && !f_valid);

endmodule : rxp_payload_port

/* File: rxp_term_model.sv */
// Terminal equipment model sampling the receive payload outputs
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Receive terminal
// ----------------------------------------------------------------
module rxp_term_model
   import rxp_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             nib_mode,
   input  wire logic             ser,
   input  wire logic [NIB_W-1:0] nib,
   input  wire logic             oh,
   input  wire logic             fr
);
   logic [1:0]     pay_q[$];      // Kept payload bits with frame flag
   logic [NIB_W:0] nib_q[$];      // Sampled nibbles with frame flag
   int             bad_idle = 0;  // Inactive outputs seen nonzero
   int             n_pulse  = 0;  // Nibble clock pulses
   int             n_fall   = 0;  // Serial clock falls
   realtime        t_rise   = 0;
   realtime        hi_max   = 0;  // Widest nibble clock high time

   // Serial sampling on the fall, overhead bits dropped
   always @(negedge clk_in) begin
      if (!nib_mode) begin
         n_fall++;
         if (nib !== 4'h0) bad_idle++;
         if (oh === 1'b0) pay_q.push_back({fr, ser});
      end else if ($realtime - t_rise > hi_max) begin
         hi_max = $realtime - t_rise;
      end
   end

   // Nibble sampling on the rise
   always @(posedge clk_in) begin
      t_rise = $realtime;
      if (nib_mode) begin
         n_pulse++;
         if (ser !== 1'b0 || oh !== 1'b0) bad_idle++;
         nib_q.push_back({fr, nib});
      end
   end
endmodule : rxp_term_model

/* File: e3_rx_payload_output_port_bench.sv */
// Self-checking bench of the receive payload output port
`timescale 1ns/1ps

module e3_rx_payload_output_port_bench
   import rxp_pkg::*;
;
   logic             sys_clk;
   logic             line_clk;
   logic             rstn;
   rxp_item_s        in_item;
   logic             in_valid;
   logic             in_ready;
   logic             mode_sel;
   logic             ser;
   logic [NIB_W-1:0] nib;
   logic             clk_out;
   logic             oh;
   logic             fr;
   logic             saw_full;
   int               miscompares = 0;
   int               n_compared  = 0;

   // ----------------------------------------------------------------
   // Clocks and instances
   // ----------------------------------------------------------------
   // Framer clock, 25 ns
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Line clock, 160 ns, offset phase
   initial begin
      line_clk = 1'b0;
      #37;
      forever #80 line_clk = ~line_clk;
   end

   rxp_payload_port rxp_payload_port_i (
      .sys_clk                 (sys_clk),
      .rstn                    (rstn),
      .in_item                 (in_item),
      .in_valid                (in_valid),
      .in_ready                (in_ready),
      .rx_recovered_line_clock (line_clk),
      .nibble_mode_select      (mode_sel),
      .rx_serial_payload_out   (ser),
      .rx_nibble_payload_out   (nib),
      .rx_payload_clock_out    (clk_out),
      .rx_overhead_bit_flag    (oh),
      .rx_frame_start_flag     (fr)
   );

   rxp_term_model rxp_term_model_i (
      .clk_in   (clk_out),
      .nib_mode (mode_sel),
      .ser      (ser),
      .nib      (nib),
      .oh       (oh),
      .fr       (fr)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // Reset with the strap set, wait out the synchroniser, clear the terminal
   task automatic reset_dut(input logic m);
      @(posedge sys_clk);
      rstn     <= 1'b0;
      in_valid <= 1'b0;
      mode_sel <= m;
      repeat (4) @(posedge line_clk);
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge line_clk);
      @(posedge sys_clk);
      saw_full = 1'b0;
      rxp_term_model_i.pay_q.delete();
      rxp_term_model_i.nib_q.delete();
      rxp_term_model_i.bad_idle = 0;
      rxp_term_model_i.n_pulse  = 0;
      rxp_term_model_i.hi_max   = 0;
   endtask : reset_dut

   // Offer one item and hold it until taken
   task automatic push(input rxp_item_s it);
      int n;
      n = 0;
      in_item  <= it;
      in_valid <= 1'b1;
      @(posedge sys_clk);
      while (in_ready !== 1'b1 && n < 400) begin
         saw_full = 1'b1;
         n++;
         @(posedge sys_clk);
      end
      if (n >= 400) check("in_ready_wait", 8'h00, 8'h01);
   endtask : push

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Serial stream with overhead bits, buffer run full
   task automatic run_serial();
      logic       exp_q[$];
      logic [1:0] pq[$];
      rxp_item_s  it;
      reset_dut(1'b0);
      for (int i = 0; i < 24; i++) begin
         it = '{sof: (i == 0), oh: (i % 5 == 2), data: i[0] ^ i[2]};
         if (!it.oh) exp_q.push_back(it.data);
         push(it);
      end
      in_valid <= 1'b0;
      @(posedge line_clk);
      rxp_term_model_i.n_fall = 0;
      repeat (40) @(posedge line_clk);
      check("serial_clock_falls", 8'h28, rxp_term_model_i.n_fall[7:0]);
      check("buffer_refused", 8'h01, {7'h0, saw_full});
      pq = rxp_term_model_i.pay_q;
      while (pq.size() > 0 && pq[0][1] !== 1'b1)
         void'(pq.pop_front());
      foreach (exp_q[k])
         check("serial_bit", {6'h0, k == 0, exp_q[k]}, {6'h0, pq[k]});
      check("idle_nibble", 8'h00, rxp_term_model_i.bad_idle[7:0]);
   endtask : run_serial

   // Nibble stream led by an overhead bit carrying frame start
   task automatic run_nibble();
      logic [11:0] bits;
      bits = 12'hA6D;
      reset_dut(1'b1);
      push('{sof: 1'b1, oh: 1'b1, data: 1'b0});
      for (int i = 11; i >= 0; i--) push('{sof: 1'b0, oh: 1'b0, data: bits[i]});
      in_valid <= 1'b0;
      repeat (40) @(posedge line_clk);
      check("nibble_pulses", 8'h03, rxp_term_model_i.n_pulse[7:0]);
      check("first_nibble", 8'h1A, {3'h0, rxp_term_model_i.nib_q[1]});
      check("second_nibble", 8'h06, {3'h0, rxp_term_model_i.nib_q[2]});
      check("last_nibble", 8'h0D, {3'h0, fr, nib});
      check("idle_serial", 8'h00, rxp_term_model_i.bad_idle[7:0]);
      check("clock_high_time", 8'h01, {7'h0, rxp_term_model_i.hi_max > 150.0
                                             && rxp_term_model_i.hi_max < 170.0});
   endtask : run_nibble

   // Two frame marks one whole frame apart in nibble mode
   task automatic run_frame();
      int n;
      reset_dut(1'b1);
      for (int i = 0; i < NIB_W * (NIB_PER_FRM + 1); i++) begin
         push('{sof: (i % (NIB_W * NIB_PER_FRM) == 0), oh: 1'b0, data: i[1]});
      end
      in_valid <= 1'b0;
      repeat (40) @(posedge line_clk);
      n = rxp_term_model_i.n_pulse - NIB_PER_FRM;
      check("frame_pulses", 8'h01, {7'h0, n == 1});
      check("first_frame_mark", 8'h01, {7'h0, rxp_term_model_i.nib_q[1][NIB_W]});
      check("next_frame_mark", 8'h01, {7'h0, fr});
   endtask : run_frame

   // Main sequence
   initial begin
      rstn     = 1'b0;
      in_valid = 1'b0;
      in_item  = '0;
      mode_sel = 1'b0;
      saw_full = 1'b0;
      run_serial();
      run_nibble();
      run_frame();
      print_verdict();
   end

   // Watchdog against a hang; a full frame takes about 0.7 ms of line clock
   initial begin
      #1000000;
      miscompares++;
      print_verdict();
   end
endmodule : e3_rx_payload_output_port_bench
